// File: rtl/lmg_pkg.sv
package lmg_pkg;

  // register byte offsets of the command port
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_LBA_LO  = 8'h04;
  localparam logic [7:0] OFS_LBA_HI  = 8'h08;
  localparam logic [7:0] OFS_PWD     = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_RES_LO  = 8'h14;
  localparam logic [7:0] OFS_RES_HI  = 8'h18;
  localparam logic [7:0] OFS_MAX_LO  = 8'h1C;
  localparam logic [7:0] OFS_MAX_HI  = 8'h20;
  localparam logic [7:0] OFS_ID8386  = 8'h24;
  localparam logic [7:0] OFS_ID128   = 8'h28;

  // opcodes
  localparam logic [7:0] OP_RD_NATIVE     = 8'hF8;
  localparam logic [7:0] OP_RD_NATIVE_EXT = 8'h27;
  localparam logic [7:0] OP_SET_MAX       = 8'hF9;
  localparam logic [7:0] OP_SET_MAX_EXT   = 8'h37;
  localparam logic [7:0] OP_SEC_SET_PW    = 8'hF1;
  localparam logic [7:0] OP_SEC_UNLOCK    = 8'hF2;
  localparam logic [7:0] OP_SEC_ERASE_PRP = 8'hF3;
  localparam logic [7:0] OP_SEC_ERASE     = 8'hF4;
  localparam logic [7:0] OP_SEC_FREEZE    = 8'hF5;
  localparam logic [7:0] OP_SEC_DISABLE   = 8'hF6;

  // set-maximum subcommands carried in the feature byte
  localparam logic [7:0] SM_ADDRESS = 8'h00;
  localparam logic [7:0] SM_SET_PW  = 8'h01;
  localparam logic [7:0] SM_LOCK    = 8'h02;
  localparam logic [7:0] SM_UNLOCK  = 8'h03;
  localparam logic [7:0] SM_FREEZE  = 8'h04;

  // media read and write opcodes gated by the lock and the maximum
  localparam int MEDIA_N = 24;
  localparam logic [7:0] MEDIA_OPS [MEDIA_N] = '{
    8'hCA, 8'h35, 8'h3D, 8'h61, 8'h3F, 8'hC5, 8'h39, 8'hCE,
    8'h30, 8'h34, 8'h3A, 8'h3B, 8'h45, 8'hC8, 8'h25, 8'h60,
    8'hC4, 8'h29, 8'h20, 8'h24, 8'h40, 8'h42, 8'h2A, 8'h2B};

  localparam logic [47:0] NATIVE_MAX_LBA = 48'h0000_00C1_ACFF;
  localparam logic [31:0] MASTER_PW_RST  = 32'h5A5A_0001; // arbitrary
  localparam logic [31:0] USER_PW_RST    = 32'h0000_0000;
  localparam logic [2:0]  ATTEMPT_LIMIT  = 3'h5;
  localparam int          ID_LIMIT_BIT   = 8;
  localparam int          ID_UNLOCK_ATTEMPTS_EXHAUSTED_BIT  = 4;

  typedef enum logic [1:0] {
    SEC_UNLK = 2'b00,
    SEC_LOCK = 2'b01,
    SEC_FROZ = 2'b10
  } lmg_sec_t;

  typedef enum logic [1:0] {
    LIM_NONE = 2'b00,
    LIM_UNLK = 2'b01,
    LIM_LOCK = 2'b10,
    LIM_FROZ = 2'b11
  } lmg_lim_t;

  typedef struct packed {
    logic       nv;
    logic [7:0] feat;
    logic [7:0] op;
  } lmg_cmd_t;

  function automatic logic lmg_is_media(input logic [7:0] op);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < MEDIA_N; i++) begin
      if (MEDIA_OPS[i] == op) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

// File: rtl/lmg_gate.sv
`timescale 1ns/1ps
`default_nettype none

module lmg_gate (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        HARD_RESET_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  input  wire logic [47:0] NV_MAX_IN,
  output logic      [31:0] RDATA_OUT,
  output logic             CMD_EXEC_OUT,
  output logic             CMD_ABORT_OUT,
  output logic      [7:0]  CMD_CODE_OUT,
  output logic             ERASE_OUT,
  output logic             NV_MAX_WE_OUT,
  output logic      [47:0] NV_MAX_OUT,
  output logic      [47:0] MAX_LBA_OUT
);
  import lmg_pkg::*;

  lmg_sec_t    sec_reg;
  lmg_lim_t    lim_reg;
  logic        loaded_reg;
  logic        lock_en_reg;
  logic [31:0] user_pw_reg;
  logic [31:0] master_pw_reg;
  logic [31:0] lim_pw_reg;
  logic [31:0] pwd_reg;
  logic [47:0] lba_reg;
  logic [47:0] max_reg;
  logic [47:0] nv_max_reg;
  logic [47:0] res_reg;
  logic [2:0]  tries_reg;
  logic        exhausted_reg;
  logic        last_abort_reg;
  logic        last_exec_reg;

  lmg_cmd_t    cmd;
  logic        go;
  logic        abort;
  logic        pw_match;
  logic        mismatch;
  logic        is_sec_pw;
  logic        lim_open;
  logic        sm_addr;

  // a write to the command offset is one command; hard reset in the same cycle drops it
  assign cmd = lmg_cmd_t'(WDATA_IN[16:0]);
  assign go  = WR_IN && (ADDR_IN == OFS_CMD) && loaded_reg && !HARD_RESET_IN;

  // security password check uses only the security passwords, never the limit one
  assign pw_match  = cmd.feat[0] ? (pwd_reg == master_pw_reg) : (pwd_reg == user_pw_reg);
  assign is_sec_pw = (cmd.op == OP_SEC_UNLOCK) || (cmd.op == OP_SEC_ERASE);
  assign mismatch  = go && is_sec_pw && (sec_reg != SEC_FROZ) && !exhausted_reg && !pw_match;
  assign lim_open  = (lim_reg == LIM_NONE) || (lim_reg == LIM_UNLK);
  assign sm_addr   = (cmd.op == OP_SET_MAX_EXT) ||
                     ((cmd.op == OP_SET_MAX) && (cmd.feat == SM_ADDRESS));

  // acceptance decision; a refusal changes only the command code, the result flags and the mismatch counter, which counts a wrong unlock or erase password
  always_comb begin
    abort = 1'b0;
    case (cmd.op)
      // a new security password may only be armed from the open state
      OP_SEC_SET_PW: begin
        abort = (sec_reg != SEC_UNLK);
      end
      // password commands close until the next reset once frozen or once the tries run out
      OP_SEC_UNLOCK, OP_SEC_ERASE: begin
        abort = (sec_reg == SEC_FROZ) || exhausted_reg || !pw_match;
      end
      // freezing is refused while locked, so a locked drive can still be opened
      OP_SEC_FREEZE: begin
        abort = (sec_reg == SEC_LOCK);
      end
      // disabling the lock needs the open state and a matching password
      OP_SEC_DISABLE: begin
        abort = (sec_reg != SEC_UNLK) || !pw_match;
      end
      // erase prepare changes no state and the erase does not need it; refused only when frozen
      OP_SEC_ERASE_PRP: begin
        abort = (sec_reg == SEC_FROZ);
      end
      OP_SET_MAX, OP_SET_MAX_EXT: begin
        // the security lock outranks the limit state
        if (sec_reg == SEC_LOCK) begin
          abort = 1'b1;
        end else if (sm_addr) begin
          // a maximum beyond the native one would expose blocks that do not exist
          abort = !lim_open || (lba_reg > NATIVE_MAX_LBA);
        end else begin
          // limit subcommands: lock needs a password, unlock needs it matched
          case (cmd.feat)
            SM_SET_PW: abort = !lim_open;
            SM_LOCK:   abort = (lim_reg != LIM_UNLK);
            SM_UNLOCK: abort = (lim_reg != LIM_LOCK) || (pwd_reg != lim_pw_reg);
            SM_FREEZE: abort = !lim_open;
            default:   abort = 1'b1;
          endcase
        end
      end
      default: begin
        // media access checks lock and limit; others pass unconditionally
        if (lmg_is_media(cmd.op)) begin
          abort = (sec_reg == SEC_LOCK) || (lba_reg > max_reg);
        end else begin
          abort = 1'b0;
        end
      end
    endcase
  end

  // argument registers written by software
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      lba_reg <= 48'h0;
      pwd_reg <= 32'h0;
    end else if (WR_IN) begin
      if (ADDR_IN == OFS_LBA_LO) begin
        lba_reg[31:0] <= WDATA_IN;
      end
      if (ADDR_IN == OFS_LBA_HI) begin
        lba_reg[47:32] <= WDATA_IN[15:0];
      end
      if (ADDR_IN == OFS_PWD) begin
        pwd_reg <= WDATA_IN;
      end
    end
  end

  // security lock state; hard reset relocks when a user password is armed
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sec_reg     <= SEC_UNLK;
      lock_en_reg <= 1'b0;
      user_pw_reg <= USER_PW_RST;
      master_pw_reg <= MASTER_PW_RST;
    end else if (HARD_RESET_IN) begin
      sec_reg <= lock_en_reg ? SEC_LOCK : SEC_UNLK;
    end else if (go && !abort) begin
      case (cmd.op)
        // feature bit 0 picks the master slot, which never arms the lock
        OP_SEC_SET_PW: begin
          if (cmd.feat[0]) begin
            master_pw_reg <= pwd_reg;
          end else begin
            user_pw_reg <= pwd_reg;
            lock_en_reg <= 1'b1;
          end
        end
        OP_SEC_UNLOCK: begin
          sec_reg <= SEC_UNLK;
        end
        // an erase wipes the user data, so the lock has nothing left to guard
        OP_SEC_ERASE: begin
          sec_reg     <= SEC_UNLK;
          lock_en_reg <= 1'b0;
        end
        // the password stays stored, only the relock at hard reset is dropped
        OP_SEC_DISABLE: begin
          lock_en_reg <= 1'b0;
        end
        // frozen lasts until the next reset of either kind
        OP_SEC_FREEZE: begin
          sec_reg <= SEC_FROZ;
        end
        default: begin
          sec_reg <= sec_reg;
        end
      endcase
    end
  end

  // mismatch counter shared by master and user tries; cleared only by resets
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tries_reg     <= 3'h0;
      exhausted_reg <= 1'b0;
    end else if (HARD_RESET_IN) begin
      tries_reg     <= 3'h0;
      exhausted_reg <= 1'b0;
    end else if (mismatch) begin
      tries_reg <= tries_reg + 3'h1;
      if ((tries_reg + 3'h1) == ATTEMPT_LIMIT) begin
        exhausted_reg <= 1'b1;
      end
    end
  end

  // limit password and state live until power loss; hard reset leaves them alone
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      lim_reg    <= LIM_NONE;
      lim_pw_reg <= 32'h0;
    end else if (go && !abort && (cmd.op == OP_SET_MAX) && !sm_addr) begin
      case (cmd.feat)
        SM_SET_PW: begin
          lim_pw_reg <= pwd_reg;
          lim_reg    <= LIM_UNLK;
        end
        // locked: only an unlock with the right password gets through
        SM_LOCK: begin
          lim_reg <= LIM_LOCK;
        end
        // back to the open limit state, the password is kept
        SM_UNLOCK: begin
          lim_reg <= LIM_UNLK;
        end
        // no way out of frozen but power loss
        SM_FREEZE: begin
          lim_reg <= LIM_FROZ;
        end
        default: begin
          lim_reg <= lim_reg;
        end
      endcase
    end
  end

  // current and stored maximum; the stored copy is taken from the pins once after power-up
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      loaded_reg <= 1'b0;
      max_reg    <= 48'h0;
      nv_max_reg <= 48'h0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      max_reg    <= NV_MAX_IN;
      nv_max_reg <= NV_MAX_IN;
    end else if (HARD_RESET_IN) begin
      // a volatile opening of the protected area closes again here
      max_reg <= nv_max_reg;
    end else if (go && !abort && sm_addr) begin
      // the stored copy only follows when the nonvolatile option is set;
      // the media write itself is the far side's job, signalled by the pulse
      max_reg <= lba_reg;
      if (cmd.nv) begin
        nv_max_reg <= lba_reg;
      end
    end
  end

  // native maximum is a constant, so a reduced limit can never leak into it
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      res_reg <= 48'h0;
    end else if (go && !abort &&
                 ((cmd.op == OP_RD_NATIVE) || (cmd.op == OP_RD_NATIVE_EXT))) begin
      res_reg <= NATIVE_MAX_LBA;
    end
  end

  // command result pulses and sticky last-result flags
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      CMD_EXEC_OUT   <= 1'b0;
      CMD_ABORT_OUT  <= 1'b0;
      CMD_CODE_OUT   <= 8'h00;
      ERASE_OUT      <= 1'b0;
      NV_MAX_WE_OUT  <= 1'b0;
      last_abort_reg <= 1'b0;
      last_exec_reg  <= 1'b0;
    end else begin
      CMD_EXEC_OUT  <= go && !abort;
      CMD_ABORT_OUT <= go && abort;
      ERASE_OUT     <= go && !abort && (cmd.op == OP_SEC_ERASE);
      NV_MAX_WE_OUT <= go && !abort && sm_addr && cmd.nv;
      // the code and last result are held; software can poll the last result in the status word
      if (go) begin
        CMD_CODE_OUT   <= cmd.op;
        last_abort_reg <= abort;
        last_exec_reg  <= !abort;
      end
    end
  end

  assign NV_MAX_OUT  = nv_max_reg;
  assign MAX_LBA_OUT = max_reg;

  // read port: data stand one cycle after the strobe, unmapped offsets read zero
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      RDATA_OUT <= 32'h0;
    end else if (RD_IN) begin
      case (ADDR_IN)
        OFS_LBA_LO: RDATA_OUT <= lba_reg[31:0];
        OFS_LBA_HI: RDATA_OUT <= {16'h0, lba_reg[47:32]};
        OFS_STATUS: RDATA_OUT <= {21'h0, lock_en_reg, tries_reg, exhausted_reg,
                                  lim_reg, sec_reg, last_exec_reg, last_abort_reg};
        OFS_RES_LO: RDATA_OUT <= res_reg[31:0];
        OFS_RES_HI: RDATA_OUT <= {16'h0, res_reg[47:32]};
        OFS_MAX_LO: RDATA_OUT <= max_reg[31:0];
        OFS_MAX_HI: RDATA_OUT <= {16'h0, max_reg[47:32]};
        // low half is word 83, high half word 86
        OFS_ID8386: begin
          RDATA_OUT <= 32'h0;
          RDATA_OUT[ID_LIMIT_BIT] <= 1'b1;
          RDATA_OUT[16 + ID_LIMIT_BIT] <= (lim_reg != LIM_NONE);
        end
        // word 128 shows only the exhausted flag here
        OFS_ID128: begin
          RDATA_OUT <= 32'h0;
          RDATA_OUT[ID_UNLOCK_ATTEMPTS_EXHAUSTED_BIT] <= exhausted_reg;
        end
        default: RDATA_OUT <= 32'h0;
      endcase
    end else begin
      // idle bus reads zero so stale data never look like a fresh answer
      RDATA_OUT <= 32'h0;
    end
  end

endmodule

`default_nettype wire

// File: tb/lmg_gate_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lmg_gate_checker (
  input wire logic        CLOCK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        HARD_RESET_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [47:0] NV_MAX_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        CMD_EXEC_OUT,
  input wire logic        CMD_ABORT_OUT,
  input wire logic [7:0]  CMD_CODE_OUT,
  input wire logic        ERASE_OUT,
  input wire logic        NV_MAX_WE_OUT,
  input wire logic [47:0] NV_MAX_OUT,
  input wire logic [47:0] MAX_LBA_OUT
);
  import lmg_pkg::*;
  // a command write; the first edge after power reset is excluded by the properties
  wire logic cmd_wr  = WR_IN && ADDR_IN == OFS_CMD;
  wire logic set_max = CMD_CODE_OUT == OP_SET_MAX || CMD_CODE_OUT == OP_SET_MAX_EXT;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  AST_ONE_RESULT: assert property (!(CMD_EXEC_OUT && CMD_ABORT_OUT))
    else $error("exec and abort together");
  AST_CMD_ANSWER: assert property (cmd_wr && !HARD_RESET_IN && $past(RESET_N_IN)
    |=> CMD_EXEC_OUT ^ CMD_ABORT_OUT) else $error("command got no result");
  AST_NO_SPURIOUS: assert property ((CMD_EXEC_OUT || CMD_ABORT_OUT) |-> $past(cmd_wr))
    else $error("result without command");
  AST_ABORT_KEEPS: assert property (CMD_ABORT_OUT |-> $stable(MAX_LBA_OUT)
    && $stable(NV_MAX_OUT) && !NV_MAX_WE_OUT && !ERASE_OUT) else $error("abort changed state");
  AST_MAX_RANGE: assert property (MAX_LBA_OUT <= NATIVE_MAX_LBA)
    else $error("maximum above native");
  AST_ID_LIMIT: assert property (RD_IN && ADDR_IN == OFS_ID8386 |=> RDATA_OUT[ID_LIMIT_BIT])
    else $error("limit support bit clear");
  AST_NV_WRITE: assert property (NV_MAX_WE_OUT |-> CMD_EXEC_OUT && set_max
    && NV_MAX_OUT == MAX_LBA_OUT) else $error("bad nonvolatile write");
  AST_ERASE: assert property (ERASE_OUT |-> CMD_EXEC_OUT && CMD_CODE_OUT == OP_SEC_ERASE)
    else $error("erase without accepted erase");
  AST_HARD_RESTORE: assert property (HARD_RESET_IN && $past(RESET_N_IN)
    |=> MAX_LBA_OUT == $past(NV_MAX_OUT)) else $error("hard reset kept volatile max");
  // the load after power reset shows up two edges after the release
  AST_MAX_CAUSE: assert property ($changed(MAX_LBA_OUT) |-> (CMD_EXEC_OUT && set_max)
    || $past(HARD_RESET_IN) || !$past(RESET_N_IN) || !$past(RESET_N_IN, 2))
    else $error("maximum changed by itself");
endmodule
bind lmg_gate lmg_gate_checker chk_i (.CLOCK_IN, .RESET_N_IN, .HARD_RESET_IN, .ADDR_IN,
  .WDATA_IN, .WR_IN, .RD_IN, .NV_MAX_IN, .RDATA_OUT, .CMD_EXEC_OUT, .CMD_ABORT_OUT,
  .CMD_CODE_OUT, .ERASE_OUT, .NV_MAX_WE_OUT, .NV_MAX_OUT, .MAX_LBA_OUT);
`default_nettype wire

// File: tb/lmg_host.sv
`timescale 1ns/1ps
`default_nettype none
module lmg_host #(
  parameter logic [47:0] NV_INIT = 48'h0000_0000_0000
) (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        nv_we_in,
  input  wire logic [47:0] nv_max_in,
  output logic      [7:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [47:0] nv_store_out
);
  // media-held maximum outlives every reset, so it lives here and not in the design
  initial begin
    nv_store_out = NV_INIT;
    forever @(posedge clk_in) if (nv_we_in) nv_store_out <= nv_max_in;
  end
  // bus idle at time zero
  initial begin
    {addr_out, wdata_out, wr_out, rd_out} = '0;
  end
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lmg_pkg::*;
  localparam logic [47:0] NVI = 48'h0000_00BB_85FF;
  localparam logic [47:0] NVL = 48'h0000_00BB_0000;
  localparam logic [7:0] ALW [8] = '{8'h70, 8'hEF, 8'hC6, 8'hE6, 8'hE2, 8'hE0, 8'hE8, 8'hB0};
  logic        clk, rst_n, hrst;
  logic [31:0] d;
  int          n_mismatch, compares;
  wire logic [7:0]  addr, code;
  wire logic [31:0] wdata, rdata;
  wire logic        wr, rd, ex, ab, er, nvwe;
  wire logic [47:0] nvs, nvmax, maxl;

  lmg_gate dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .HARD_RESET_IN(hrst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .NV_MAX_IN(nvs), .RDATA_OUT(rdata),
    .CMD_EXEC_OUT(ex), .CMD_ABORT_OUT(ab), .CMD_CODE_OUT(code), .ERASE_OUT(er),
    .NV_MAX_WE_OUT(nvwe), .NV_MAX_OUT(nvmax), .MAX_LBA_OUT(maxl));
  lmg_host #(.NV_INIT(NVI)) h (.clk_in(clk), .rdata_in(rdata), .nv_we_in(nvwe),
    .nv_max_in(nvmax), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
    .nv_store_out(nvs));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // issue one command and judge its one-cycle result pulse
  task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic nv, input logic e);
    h.wr(OFS_CMD, {15'h0, nv, ft, op});
    #1 chk({ex, ab, code}, {e, !e, op});
  endtask
  task automatic lba(input logic [47:0] v);
    h.wr(OFS_LBA_LO, v[31:0]);
    h.wr(OFS_LBA_HI, {16'h0, v[47:32]});
  endtask
  task automatic sts;
    h.rd(OFS_STATUS, d);
  endtask
  task automatic hr;
    @(posedge clk) hrst <= 1'b1;
    @(posedge clk) hrst <= 1'b0;
    // let the edge that takes the pulse settle before anyone looks
    #1;
  endtask
  // power reset; the first edge after release only loads the stored maximum
  task automatic pr;
    @(posedge clk) rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_hpa;
    chk(maxl, NVI);
    cmd(OP_RD_NATIVE, SM_ADDRESS, 1'b0, 1'b1);
    h.rd(OFS_RES_LO, d); chk(d, NATIVE_MAX_LBA[31:0]);
    lba(NATIVE_MAX_LBA); cmd(OP_SET_MAX, SM_ADDRESS, 1'b0, 1'b1);
    chk({maxl, nvmax}, {NATIVE_MAX_LBA, NVI});
    h.rd(OFS_MAX_LO, d); chk(d, NATIVE_MAX_LBA[31:0]);
    cmd(8'hCA, SM_ADDRESS, 1'b0, 1'b1);
    hr; chk(maxl, NVI);
    cmd(8'hCA, SM_ADDRESS, 1'b0, 1'b0);
    lba(NATIVE_MAX_LBA + 48'h1); cmd(OP_SET_MAX_EXT, SM_ADDRESS, 1'b0, 1'b0);
    lba(NVL); cmd(OP_SET_MAX_EXT, SM_ADDRESS, 1'b1, 1'b1); chk(nvmax, NVL);
    pr; chk(maxl, NVL);
  endtask

  task automatic t_lim;
    h.wr(OFS_PWD, 32'h1234_5678);
    cmd(OP_SET_MAX, SM_LOCK, 1'b0, 1'b0);
    cmd(OP_SET_MAX, SM_SET_PW, 1'b0, 1'b1);
    h.rd(OFS_ID8386, d); chk({d[24], d[8]}, 2'b11);
    cmd(OP_SET_MAX, SM_LOCK, 1'b0, 1'b1);
    hr; sts; chk(d[5:4], 2'b10);
    lba(NVL); cmd(OP_SET_MAX, SM_ADDRESS, 1'b0, 1'b0);
    cmd(OP_SET_MAX_EXT, SM_ADDRESS, 1'b0, 1'b0);
    h.wr(OFS_PWD, USER_PW_RST); cmd(OP_SET_MAX, SM_UNLOCK, 1'b0, 1'b0);
    h.wr(OFS_PWD, 32'h1234_5678); cmd(OP_SET_MAX, SM_UNLOCK, 1'b0, 1'b1);
    sts; chk(d[5:4], 2'b01);
    cmd(OP_SET_MAX, SM_FREEZE, 1'b0, 1'b1);
    cmd(OP_SET_MAX, SM_UNLOCK, 1'b0, 1'b0);
    cmd(OP_SET_MAX, SM_ADDRESS, 1'b0, 1'b0);
    pr; sts; chk(d[5:4], 2'b00);
  endtask

  task automatic t_sec;
    lba(48'h0); h.wr(OFS_PWD, 32'h0000_ABCD);
    cmd(OP_SEC_SET_PW, 8'h00, 1'b0, 1'b1);
    hr; sts; chk(d[3:2], 2'b01);
    foreach (MEDIA_OPS[i]) cmd(MEDIA_OPS[i], 8'h00, 1'b0, 1'b0);
    cmd(OP_SET_MAX, SM_ADDRESS, 1'b0, 1'b0); cmd(OP_SET_MAX_EXT, SM_ADDRESS, 1'b0, 1'b0);
    foreach (ALW[i]) cmd(ALW[i], 8'h00, 1'b0, 1'b1);
    cmd(OP_SEC_FREEZE, 8'h00, 1'b0, 1'b0); cmd(OP_SEC_SET_PW, 8'h00, 1'b0, 1'b0);
    h.wr(OFS_PWD, 32'h1234_5678);
    repeat (5) cmd(OP_SEC_UNLOCK, 8'h00, 1'b0, 1'b0);
    h.wr(OFS_PWD, 32'h0000_ABCD); cmd(OP_SEC_UNLOCK, 8'h00, 1'b0, 1'b0);
    h.rd(OFS_ID128, d); chk(d[ID_UNLOCK_ATTEMPTS_EXHAUSTED_BIT], 1'b1);
    hr; sts; chk(d[9:6], 4'h0);
    cmd(OP_SEC_UNLOCK, 8'h00, 1'b0, 1'b1); cmd(8'hCA, 8'h00, 1'b0, 1'b1);
    cmd(OP_SEC_FREEZE, 8'h00, 1'b0, 1'b1); cmd(OP_SEC_UNLOCK, 8'h00, 1'b0, 1'b0);
    cmd(OP_SEC_ERASE, 8'h00, 1'b0, 1'b0); cmd(OP_SEC_SET_PW, 8'h00, 1'b0, 1'b0);
    cmd(8'hCA, 8'h00, 1'b0, 1'b1); cmd(OP_SET_MAX_EXT, SM_ADDRESS, 1'b0, 1'b1);
    hr; cmd(OP_SEC_ERASE, 8'h00, 1'b0, 1'b1); chk(er, 1'b1);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole run needs a few hundred cycles; this limit only cuts a hang short
  initial begin
    #100000;
    n_mismatch++;
    summarize;
  end

  initial begin
    rst_n = 1'b0;
    hrst  = 1'b0;
    pr;
    t_hpa;
    t_lim;
    t_sec;
    summarize;
  end
endmodule
`default_nettype wire
